// file: rtl/mabs_pkg.sv
/*
 * Constants, register map and types of the AIS burst scheduler.
 * Assumes a 25 MHz pclk and a GNSS receiver that gives a UTC minute pulse and a lock level.
 */
//
// Functional notes
// - Each transmission can go to either channel.
// - First slot of first burst is random.
// - Burst is eight fixed-offset transmissions.
// - Transmissions 75 slots apart, channel toggles.
// - Active: time-out 7 first, then counts down.
// - Every slot is a free random candidate.
// - Next set of bursts one minute, six seconds; code picks 54 to 66 seconds at random.
// - Same time-out on every report in burst.
// - Safety texts 5th, 6th at time-out 7, 3.
// - Safety texts alternate between the two channels.
// - Test: one burst, time-out 0, sub-message 0.
// - Test: safety texts first and eighth transmission.
// - Active: status 14, text active.
// - Test: status 15, text test.
// - Keyed over two seconds forces transmitter off.
// - No UTC lock in five minutes leaves test.
package mabs_pkg;
	// ==========================================================
	// Register map.
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_SEED = 8'h08;
	localparam logic [7:0] OFF_SLOT = 8'h0C;
	localparam int CTRL_ACTIVE_BIT = 0;
	localparam int CTRL_TEST_BIT = 1;
	localparam int CTRL_STOP_BIT = 2;
	localparam logic [15:0] SEED_RESET = 16'hACE1;
	// ==========================================================
	// Timing.
	localparam int CLK_HZ = 25000000;
	localparam int MINUTE_S = 60;
	localparam int SLOTS_PER_MIN = 2250;
	localparam int SLOT_CYC_DEF = CLK_HZ * MINUTE_S / SLOTS_PER_MIN;
	localparam int WDOG_MS = 2000;
	localparam int WDOG_CYC_DEF = (CLK_HZ / 1000) * WDOG_MS;
	localparam int TEST_WAIT_S = 300;
	localparam int SEC_CYC_DEF = CLK_HZ;
	localparam int BIT_RATE = 9600;
	localparam int BIT_CYC_DEF = CLK_HZ / BIT_RATE;
	localparam int TRAIN_BITS = 24;
	localparam int FRAME_BITS_DEF = 255;
	// ==========================================================
	// Burst layout.
	localparam int BURST_LEN = 8;
	localparam int TX_GAP = 75;
	localparam int BURST_SPAN = (BURST_LEN - 1) * TX_GAP;
	localparam int SET_OFF_MIN = 2025;
	localparam int SET_OFF_RANGE = 451;
	localparam logic [2:0] STO_FIRST = 3'h7;
	localparam logic [2:0] STO_TEXT2 = 3'h3;
	localparam logic [3:0] NAV_ACTIVE = 4'hE;
	localparam logic [3:0] NAV_TEST = 4'hF;
	typedef enum logic [1:0] {
		MABS_IDLE = 2'b00,
		MABS_ACTIVE = 2'b01,
		MABS_WAIT = 2'b10,
		MABS_TEST = 2'b11
	} mabs_mode_t;
endpackage : mabs_pkg

// file: rtl/mabs_top.sv
/*
 * AIS burst scheduler: slot timing, burst schedule, message fields, frame serialiser,
 * transmit watchdog and APB register slave.
 * Assumes GNSS pins are asynchronous and the payload source runs on pclk.
 */
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module mabs_top
	import mabs_pkg::*;
#(
	parameter int SLOT_CYC = SLOT_CYC_DEF,
	parameter int WDOG_CYC = WDOG_CYC_DEF,
	parameter int SEC_CYC = SEC_CYC_DEF,
	parameter int BIT_CYC = BIT_CYC_DEF,
	parameter int FRAME_BITS = FRAME_BITS_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic utc_lock,
	input wire logic utc_minute,
	input wire logic tx_payload,
	output logic tx_payload_req,
	output logic tx_key,
	output logic tx_bit,
	output logic tx_chan,
	output logic tx_safety,
	output logic [3:0] tx_nav,
	output logic [2:0] tx_sto,
	output logic [13:0] tx_submsg,
	output logic tx_fault
);
	// ==========================================================
	// Pin synchronisers.
	logic lock_m, lock_s, min_m, min_s, min_d;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_m <= 1'b0;
			lock_s <= 1'b0;
			min_m <= 1'b0;
			min_s <= 1'b0;
			min_d <= 1'b0;
		end else begin
			lock_m <= utc_lock;
			lock_s <= lock_m;
			min_m <= utc_minute;
			min_s <= min_m;
			min_d <= min_s;
		end
	end
	wire logic min_edge = min_s & ~min_d;

	// ==========================================================
	// APB decode.
	wire logic setup = psel & ~penable;
	wire logic acc = psel & penable & pready;
	wire logic wr_ctrl = acc & pwrite & (paddr == OFF_CTRL);
	wire logic go_active = wr_ctrl & pwdata[CTRL_ACTIVE_BIT];
	wire logic go_test = wr_ctrl & pwdata[CTRL_TEST_BIT];
	wire logic go_stop = wr_ctrl & pwdata[CTRL_STOP_BIT];

	// ==========================================================
	// Slot timing.
	logic [19:0] cyc_cnt;
	logic [11:0] slot_num;
	logic slot_tick;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cyc_cnt <= '0;
			slot_num <= '0;
			slot_tick <= 1'b0;
		end else if (min_edge) begin
			cyc_cnt <= '0;
			slot_num <= '0;
			slot_tick <= 1'b1;
		end else if (cyc_cnt == 20'(SLOT_CYC - 1)) begin
			cyc_cnt <= '0;
			slot_tick <= 1'b1;
			slot_num <= (slot_num == 12'(SLOTS_PER_MIN - 1)) ? '0 : slot_num + 12'd1;
		end else begin
			cyc_cnt <= cyc_cnt + 20'd1;
			slot_tick <= 1'b0;
		end
	end

	// ==========================================================
	// Random source.
	logic [15:0] lfsr;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lfsr <= SEED_RESET;
		end else if (acc & pwrite & (paddr == OFF_SEED)) begin
			lfsr <= (pwdata[15:0] == 16'h0000) ? SEED_RESET : pwdata[15:0];
		end else begin
			lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		end
	end
	wire logic [11:0] rnd_first = 12'(lfsr % 16'(SLOTS_PER_MIN));
	wire logic [11:0] rnd_set = 12'(SET_OFF_MIN) + 12'(lfsr % 16'(SET_OFF_RANGE));

	// ==========================================================
	// Mode control.
	mabs_mode_t mode;
	logic [8:0] sec_cnt;
	logic [24:0] sec_tmr;
	logic abandoned;
	logic [11:0] wait_cnt;
	logic [2:0] burst_idx;
	logic [2:0] sto;
	logic [11:0] set_off;
	wire logic running = (mode == MABS_ACTIVE) | (mode == MABS_TEST);
	wire logic tx_go = slot_tick & running & (wait_cnt == 12'd0) & ~tx_fault;
	wire logic last_tx = tx_go & (burst_idx == 3'(BURST_LEN - 1));
	wire logic start_act = (mode == MABS_IDLE) & go_active;
	wire logic start_test = (mode == MABS_WAIT) & lock_s & ~go_stop;
	wire logic wait_out = (mode == MABS_WAIT) & ~lock_s & (sec_cnt == 9'(TEST_WAIT_S));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode <= MABS_IDLE;
		end else if (go_stop) begin
			mode <= MABS_IDLE;
		end else begin
			unique case (mode)
				MABS_IDLE: begin
					if (go_active) begin
						mode <= MABS_ACTIVE;
					end else if (go_test) begin
						mode <= MABS_WAIT;
					end
				end
				MABS_WAIT: begin
					if (lock_s) begin
						mode <= MABS_TEST;
					end else if (wait_out) begin
						mode <= MABS_IDLE;
					end
				end
				MABS_TEST: begin
					if (last_tx) begin
						mode <= MABS_IDLE;
					end
				end
				MABS_ACTIVE: begin
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sec_cnt <= '0;
			sec_tmr <= '0;
		end else if (mode != MABS_WAIT) begin
			sec_cnt <= '0;
			sec_tmr <= '0;
		end else if (sec_tmr == 25'(SEC_CYC - 1)) begin
			sec_tmr <= '0;
			sec_cnt <= sec_cnt + 9'd1;
		end else begin
			sec_tmr <= sec_tmr + 25'd1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			abandoned <= 1'b0;
		end else if (wait_out) begin
			abandoned <= 1'b1;
		end else if (wr_ctrl) begin
			abandoned <= 1'b0;
		end
	end

	// ==========================================================
	// Burst schedule.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_cnt <= '0;
			burst_idx <= '0;
			sto <= '0;
			set_off <= 12'(SET_OFF_MIN);
		end else if (start_act | start_test) begin
			wait_cnt <= rnd_first;
			burst_idx <= '0;
			sto <= start_act ? STO_FIRST : 3'h0;
		end else if (slot_tick & running) begin
			if (wait_cnt != 12'd0) begin
				wait_cnt <= wait_cnt - 12'd1;
			end else if (!last_tx) begin
				wait_cnt <= 12'(TX_GAP - 1);
				burst_idx <= burst_idx + 3'd1;
			end else begin
				burst_idx <= '0;
				if (sto != 3'h0) begin
					sto <= sto - 3'h1;
					wait_cnt <= 12'(SLOTS_PER_MIN - BURST_SPAN - 1);
					if (sto == 3'h1) begin
						set_off <= rnd_set;
					end
				end else begin
					sto <= STO_FIRST;
					wait_cnt <= set_off - 12'(BURST_SPAN + 1);
				end
			end
		end
	end

	// ==========================================================
	// Per-transmission message fields.
	wire logic text_act = ((sto == STO_FIRST) | (sto == STO_TEXT2)) &
		((burst_idx == 3'd4) | (burst_idx == 3'd5));
	wire logic text_test = (burst_idx == 3'd0) | (burst_idx == 3'(BURST_LEN - 1));
	logic [13:0] submsg_act;
	always_comb begin
		submsg_act = 14'h0000;
		if (sto == 3'h0) begin
			submsg_act = 14'(set_off);
		end else if (!sto[0]) begin
			submsg_act = 14'(slot_num);
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_chan <= 1'b0;
			tx_safety <= 1'b0;
			tx_nav <= NAV_ACTIVE;
			tx_sto <= '0;
			tx_submsg <= '0;
		end else if (tx_go) begin
			tx_chan <= ~tx_chan;
			if (mode == MABS_TEST) begin
				tx_safety <= text_test;
				tx_nav <= NAV_TEST;
				tx_sto <= 3'h0;
				tx_submsg <= 14'h0000;
			end else begin
				tx_safety <= text_act;
				tx_nav <= NAV_ACTIVE;
				tx_sto <= sto;
				tx_submsg <= submsg_act;
			end
		end
	end

	// ==========================================================
	// Frame serialiser.
	logic [7:0] bit_cnt;
	logic [11:0] bit_tmr;
	wire logic [7:0] nxt_bit = bit_cnt + 8'd1;
	wire logic raw_next = (nxt_bit < 8'(TRAIN_BITS)) ? nxt_bit[0] : tx_payload;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_key <= 1'b0;
			tx_bit <= 1'b0;
			bit_cnt <= '0;
			bit_tmr <= '0;
			tx_payload_req <= 1'b0;
		end else begin
			tx_payload_req <= 1'b0;
			if (tx_fault) begin
				tx_key <= 1'b0;
			end else if (tx_go) begin
				tx_key <= 1'b1;
				tx_bit <= ~tx_bit;
				bit_cnt <= '0;
				bit_tmr <= '0;
			end else if (tx_key) begin
				if (bit_tmr == 12'(BIT_CYC - 1)) begin
					bit_tmr <= '0;
					if (bit_cnt == 8'(FRAME_BITS - 1)) begin
						tx_key <= 1'b0;
					end else begin
						bit_cnt <= nxt_bit;
						tx_bit <= raw_next ? tx_bit : ~tx_bit;
						tx_payload_req <= (nxt_bit >= 8'(TRAIN_BITS));
					end
				end else begin
					bit_tmr <= bit_tmr + 12'd1;
				end
			end
		end
	end

	// ==========================================================
	// Transmit watchdog.
	logic [25:0] key_cnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key_cnt <= '0;
			tx_fault <= 1'b0;
		end else if (!tx_key) begin
			key_cnt <= '0;
		end else if (key_cnt >= 26'(WDOG_CYC)) begin
			tx_fault <= 1'b1;
		end else begin
			key_cnt <= key_cnt + 26'd1;
		end
	end

	// ==========================================================
	// APB answer.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= setup;
			if (setup) begin
				pslverr <= 1'b0;
				prdata <= '0;
				unique case (paddr)
					OFF_CTRL: prdata <= '0;
					OFF_STATUS: prdata <= {21'h0_0000, lock_s, abandoned, tx_fault,
						burst_idx, sto, mode};
					OFF_SEED: prdata <= {16'h0000, lfsr};
					OFF_SLOT: prdata <= {20'h0_0000, slot_num};
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

	// ==========================================================
	// Checks.
	logic [11:0] since_tx;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			since_tx <= '0;
		end else if (tx_go) begin
			since_tx <= 12'd1;
		end else if (slot_tick & (since_tx != 12'hFFF)) begin
			since_tx <= since_tx + 12'd1;
		end
	end

	property p_gap;
		@(posedge pclk) disable iff (!presetn)
		tx_go && burst_idx != 3'd0 |-> since_tx == 12'(TX_GAP);
	endproperty
	a_gap: assert property (p_gap) else $error("transmission spacing not 75 slots");

	property p_chan;
		@(posedge pclk) disable iff (!presetn)
		tx_go |=> tx_chan != $past(tx_chan);
	endproperty
	a_chan: assert property (p_chan) else $error("channel did not toggle");

	property p_sto_same;
		@(posedge pclk) disable iff (!presetn)
		tx_go && burst_idx != 3'd0 && mode == MABS_ACTIVE |=> tx_sto == $past(tx_sto);
	endproperty
	a_sto_same: assert property (p_sto_same) else $error("time-out changed in burst");

	property p_sto_dec;
		@(posedge pclk) disable iff (!presetn)
		last_tx && mode == MABS_ACTIVE && sto != 3'h0 |=> sto == $past(sto) - 3'h1;
	endproperty
	a_sto_dec: assert property (p_sto_dec) else $error("time-out not decremented");

	property p_test_fields;
		@(posedge pclk) disable iff (!presetn)
		tx_go && mode == MABS_TEST |=> tx_sto == 3'h0 && tx_submsg == 14'h0000 &&
			tx_nav == NAV_TEST && tx_safety == (burst_idx == 3'd1 || burst_idx == 3'd0);
	endproperty
	a_test_fields: assert property (p_test_fields) else $error("test fields wrong");

	property p_text_act;
		@(posedge pclk) disable iff (!presetn)
		tx_go && mode == MABS_ACTIVE |=> tx_nav == NAV_ACTIVE &&
			tx_safety == ((tx_sto == 3'h7 || tx_sto == 3'h3) &&
			(burst_idx == 3'd5 || burst_idx == 3'd6));
	endproperty
	a_text_act: assert property (p_text_act) else $error("active text wrong");

	property p_wdog;
		@(posedge pclk) disable iff (!presetn)
		key_cnt == 26'(WDOG_CYC) |-> ##2 tx_fault && !tx_key;
	endproperty
	a_wdog: assert property (p_wdog) else $error("key held past watchdog");

	property p_abandon;
		@(posedge pclk) disable iff (!presetn)
		wait_out && !go_stop |=> mode == MABS_IDLE && abandoned && !tx_key;
	endproperty
	a_abandon: assert property (p_abandon) else $error("test not abandoned");

	property p_train;
		@(posedge pclk) disable iff (!presetn)
		tx_go |=> tx_key && bit_cnt == 8'd0 && tx_bit != $past(tx_bit);
	endproperty
	a_train: assert property (p_train) else $error("frame start wrong");

	c_burst_end: cover property (@(posedge pclk) disable iff (!presetn) last_tx);
	c_test_done: cover property (@(posedge pclk) disable iff (!presetn)
		mode == MABS_TEST ##1 mode == MABS_IDLE);
	c_text: cover property (@(posedge pclk) disable iff (!presetn) tx_go && text_act);
	c_fault: cover property (@(posedge pclk) disable iff (!presetn) $rose(tx_fault));
endmodule : mabs_top
`default_nettype wire

// file: tb/mabs_rx_model.sv
/*
 * Receiver model of the far side: it follows the keyed line, undoes NRZI and checks each frame.
 * Assumes tx_key and tx_bit change just after rising pclk edges and bits start with the key.
 */
`timescale 1ns/10ps
`default_nettype none
module mabs_rx_model #(
	parameter int BIT_CYC = 1,
	parameter int FRAME_BITS = 26
) (
	input wire logic pclk,
	input wire logic tx_key,
	input wire logic tx_bit,
	output logic rx_done = 1'b0,
	output logic rx_ok = 1'b0
);
	// ==========================================================
	// Frame decoder.
	int n = 0;
	logic prev = 1'b0;
	logic bad = 1'b0;
	always @(posedge pclk) begin
		rx_done <= 1'b0;
		if (tx_key === 1'b1) begin
			if (n % BIT_CYC == 0) begin
				if (n / BIT_CYC < 24 && (tx_bit === prev) !== ((n / BIT_CYC) % 2 == 1)) begin
					bad = 1'b1;
				end
				prev = tx_bit;
			end
			n++;
		end else begin
			if (n != 0) begin
				rx_done <= 1'b1;
				rx_ok <= !bad && n == FRAME_BITS * BIT_CYC;
			end
			n = 0;
			bad = 1'b0;
			prev = tx_bit;
		end
	end
endmodule : mabs_rx_model
`default_nettype wire

// file: tb/mabs_top_tb.sv
/*
 * Self-checking bench of the burst scheduler: APB registers, test abandon, test and active bursts.
 * Assumes the receiver model beside it and shortened slot, bit and second counts.
 */
`timescale 1ns/10ps
`default_nettype none
module mabs_top_tb;
	import mabs_pkg::*;
	// ==========================================================
	// Signals and counters.
	localparam int SLOT = 27;
	localparam int LIMIT = 100000;
	localparam int BITC = 1;
	localparam int FRM = 26;
	localparam int WDOG = 20000;
	localparam int SECC = 4;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr, utc_lock = 1'b0, tx_payload = 1'b0, tx_payload_req, tx_key, tx_bit;
	logic tx_chan, tx_safety, tx_fault, rx_done, rx_ok, key_q = 1'b0, last_chan, tmode = 1'b0;
	logic [3:0] tx_nav;
	logic [2:0] tx_sto;
	logic [13:0] tx_submsg;
	logic utc_minute = 1'b0;
	logic [2:0] es;
	logic [31:0] r, sd, seed = 32'h0ccb;
	logic e;
	int checks = 0, fail_count = 0, cyc = 0, t_rise = 0, nrise = 0, nfr = 0, k;
	int t_burst = 0, npay = 0;
	always #20 pclk = ~pclk;
	mabs_top #(.SLOT_CYC(SLOT), .WDOG_CYC(WDOG), .SEC_CYC(SECC), .BIT_CYC(BITC),
		.FRAME_BITS(FRM))
	mabs_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.utc_lock(utc_lock), .utc_minute(utc_minute), .tx_payload(tx_payload),
		.tx_payload_req(tx_payload_req), .tx_key(tx_key), .tx_bit(tx_bit), .tx_chan(tx_chan),
		.tx_safety(tx_safety), .tx_nav(tx_nav), .tx_sto(tx_sto), .tx_submsg(tx_submsg),
		.tx_fault(tx_fault));
	mabs_rx_model #(.BIT_CYC(BITC), .FRAME_BITS(FRM)) mabs_rx_model_i (.pclk(pclk), .tx_key(tx_key),
		.tx_bit(tx_bit), .rx_done(rx_done), .rx_ok(rx_ok));
	// ==========================================================
	// Tasks and expectations.
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task give_verdict;
		$display("Comparisons %0d, mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : give_verdict
	function automatic logic [2:0] exp_sto(input logic t, input int n);
		return t ? 3'h0 : 3'(STO_FIRST - (n / BURST_LEN - 1));
	endfunction : exp_sto
	function automatic logic exp_safety(input logic t, input int i, input logic [2:0] s);
		return t ? (i == 0 || i == BURST_LEN - 1) :
			((s == STO_FIRST || s == STO_TEXT2) && (i == 4 || i == 5));
	endfunction : exp_safety
	// ==========================================================
	// Payload, timeout, spacing and frame checks.
	always @(posedge pclk) begin
		tx_payload <= 1'($random(seed));
		cyc++;
		if (cyc > LIMIT) begin
			fail_count++;
			give_verdict();
		end
		if (tx_key === 1'b1 && key_q === 1'b0) begin
			if (nrise % BURST_LEN != 0) chk(cyc - t_rise, TX_GAP * SLOT);
			if (nrise == 2 * BURST_LEN) chk(cyc - t_burst, SLOTS_PER_MIN * SLOT);
			if (nrise % BURST_LEN == 0) t_burst = cyc;
			t_rise = cyc;
			nrise++;
		end
		key_q = tx_key;
	end
	always @(posedge pclk) begin
		if (tx_payload_req === 1'b1) npay++;
		if (rx_done === 1'b1) begin
			k = nfr % BURST_LEN;
			es = exp_sto(tmode, nfr);
			chk(rx_ok, 1'b1);
			chk(npay, FRM - TRAIN_BITS);
			npay = 0;
			chk(tx_nav, tmode ? NAV_TEST : NAV_ACTIVE);
			chk(tx_safety, exp_safety(tmode, k, es));
			if (!exp_safety(tmode, k, es)) chk(tx_sto, es);
			if (tmode) chk(tx_submsg, 14'h0000);
			if (nfr > 0) chk(tx_chan, !last_chan);
			chk(tx_fault, 1'b0);
			last_chan = tx_chan;
			nfr++;
		end
	end
	// ==========================================================
	// Main sequence.
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFF_STATUS, 32'h0000_0000);
		chk(r[1:0], 2'h0);
		apb(1'b0, 8'h10, 32'h0000_0000);
		chk(e, 1'b1);
		chk(r, 32'h0000_0000);
		repeat (5 * SLOT) @(posedge pclk);
		utc_minute <= 1'b1;
		repeat (3) @(posedge pclk);
		utc_minute <= 1'b0;
		apb(1'b0, OFF_SLOT, 32'h0000_0000);
		chk(r, 32'h0000_0000);
		sd = $random(seed);
		apb(1'b1, OFF_SEED, {16'h0000, sd[15:0]});
		$display("done: registers");
		apb(1'b1, OFF_CTRL, 32'h0000_0001 << CTRL_TEST_BIT);
		repeat (TEST_WAIT_S * SECC + 100) @(posedge pclk);
		apb(1'b0, OFF_STATUS, 32'h0000_0000);
		chk({r[9], r[1:0]}, 3'h4);
		chk(nfr, 0);
		$display("done: test abandoned");
		utc_lock <= 1'b1;
		tmode = 1'b1;
		// A seed of one keeps the first slot of the first burst early.
		apb(1'b1, OFF_SEED, 32'h0000_0001);
		apb(1'b1, OFF_CTRL, 32'h0000_0001 << CTRL_TEST_BIT);
		while (nfr < BURST_LEN) @(posedge pclk);
		repeat (100 * SLOT) @(posedge pclk);
		chk(nfr, BURST_LEN);
		apb(1'b0, OFF_STATUS, 32'h0000_0000);
		chk({r[9], r[1:0]}, 3'h0);
		$display("done: test burst");
		tmode = 1'b0;
		apb(1'b1, OFF_SEED, 32'h0000_0001);
		apb(1'b1, OFF_CTRL, 32'h0000_0001 << CTRL_ACTIVE_BIT);
		apb(1'b0, OFF_STATUS, 32'h0000_0000);
		chk(r[1:0], 2'h1);
		while (nfr < 3 * BURST_LEN) @(posedge pclk);
		apb(1'b1, OFF_CTRL, 32'h0000_0001 << CTRL_STOP_BIT);
		apb(1'b0, OFF_STATUS, 32'h0000_0000);
		chk(r[1:0], 2'h0);
		$display("done: active burst");
		give_verdict();
	end
endmodule : mabs_top_tb
`default_nettype wire
